// >>> verilog/scps_pkg.sv
// constants, field layouts and types of the system clock source block
// Behaviour
// R1: selected oscillator or pll output is halved to form instruction and peripheral clocks
// R2: source codes 000 fast rc, 001 rc with pll, 010 primary, 011 primary with pll
// R3: source codes 100 secondary, 101 slow rc, 110 rc by 16, 111 postscaled rc
// R4: primary mode 00 external clock, 01 standard crystal, 10 high-speed crystal
// R5: an erased configuration starts in postscaled fast rc mode, code 111
// R6: at power-on the source comes from the nonvolatile source and primary mode fields
// R7: fast rc divided by a three-bit postscale field, down to 1:256
// R8: pll reference divided by five-bit prescale field plus two, 2 to 33
// R9: vco input multiplied by nine-bit feedback field plus two
// R10: vco output divided by 2, 4 or 8
// R11: postscale code 00 is /2, 01 is /4, 11 is /8, 10 reserved
// R12: pll output is reference times feedback over prescale times postscale
// R13: software keeps the vco input between 0.8 and 8 MHz
// R14: software keeps the vco output between 100 and 200 MHz
// R15: software keeps the pll output between 12.5 and 80 MHz
// R16: only primary or fast rc may feed the pll, others bypass it
// R17: slow rc also clocks the watchdog and the fail-safe monitor
// R18: instruction clock rate up to 40 MHz is supported
// R19: when the second primary pin is unused its function follows a config bit
// R20: auxiliary oscillator on secondary pins, crystal or external clock up to 64 MHz
// R21: fail-safe monitor detects loss of the active clock and falls back
// R22: divider settings change only at divider boundaries, never producing runt ticks; pll feedback and postscale settings take effect at once
package scps_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int INSTR_MAX_MHZ = 40;

    localparam logic [7:0] OFS_CLOCK_DIVISOR = 8'h00;
    localparam logic [7:0] OFS_FEEDBACK_DIVISOR = 8'h04;
    localparam logic [7:0] OFS_OSC_STATUS = 8'h08;
    localparam logic [7:0] OFS_AUX_CONTROL = 8'h0c;

    localparam int FRC_POST_LSB = 8;
    localparam int PLL_POST_LSB = 6;
    localparam int PLL_PRE_LSB = 0;
    localparam int AUX_MODE_LSB = 11;
    localparam int AUX_DIV_LSB = 8;
    localparam int ST_SRC_LSB = 0;
    localparam int ST_PMODE_LSB = 4;
    localparam int ST_PINFN_BIT = 6;
    localparam int ST_FAILSAFE_CLOCK_MONITOR_EN_BIT = 7;
    localparam int ST_LOCK_BIT = 8;
    localparam int ST_FAIL_BIT = 9;

    localparam logic [2:0] FRC_POST_RST = 3'h0;
    localparam logic [1:0] PLL_POST_RST = 2'h1;
    localparam logic [4:0] PLL_PRE_RST = 5'h00;
    localparam logic [8:0] PLL_FBD_RST = 9'h030;
    localparam logic [1:0] AUX_MODE_RST = 2'h0;
    localparam logic [2:0] AUX_DIV_RST = 3'h0;
    localparam logic [2:0] ERASED_SOURCE = 3'h7;

    localparam logic [2:0] SRC_FAST_RC = 3'h0;
    localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
    localparam logic [2:0] SRC_SECONDARY = 3'h4;
    localparam logic [2:0] SRC_SLOW_RC = 3'h5;
    localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FAST_RC_POST = 3'h7;

    localparam logic [1:0] PMODE_EXTERNAL = 2'h0;
    localparam logic [1:0] PMODE_STD_CRYSTAL = 2'h1;
    localparam logic [1:0] PMODE_HS_CRYSTAL = 2'h2;
    localparam logic [1:0] PLL_POST_RESERVED = 2'h2;
    localparam logic [1:0] AUX_OFF = 2'h0;

    localparam logic [5:0] PLL_PRE_OFFSET = 6'h02;
    localparam logic [9:0] PLL_FBD_OFFSET = 10'h002;
    localparam logic [8:0] DIV_SIXTEEN = 9'h010;

    // lock timing is counted in vco-input ticks, fail-safe timing in slow rc ticks
    localparam logic [3:0] PLL_LOCK_TICKS = 4'h8;
    localparam logic [1:0] FAIL_SLOW_TICKS = 2'h2;
    localparam logic [1:0] BOOT_SYNC_CYCLES = 2'h2;
    localparam int N_PINS = 4;

    typedef enum logic [2:0] {
        SCPS_PLL_OFF = 3'b001,
        SCPS_PLL_ACQ = 3'b010,
        SCPS_PLL_LOCKED = 3'b100
    } scps_pll_state_t;

    typedef struct packed {
        logic [2:0] fast_rc_postscale_sel;
        logic [1:0] pll_postscale_sel;
        logic [4:0] pll_prescale_sel;
    } scps_divisor_t;

    typedef struct packed {
        logic [2:0] initial_source_sel;
        logic [1:0] primary_mode_sel;
        logic second_pin_function_bit;
        logic failsafe_clock_monitor_enable;
    } scps_boot_cfg_t;

    // 000 /1 up to 110 /64, 111 /256
    function automatic logic [8:0] scps_frc_post_div(input logic [2:0] sel);
        logic [8:0] d;
        d = (sel == 3'h7) ? 9'h100 : (9'h001 << sel);
        return d;
    endfunction

    function automatic logic [3:0] scps_pll_post_div(input logic [1:0] sel);
        logic [3:0] d;
        unique case (sel)
            2'h0: d = 4'h2;
            2'h1: d = 4'h4;
            default: d = 4'h8;
        endcase
        return d;
    endfunction

endpackage

// >>> verilog/scps_edge_sync.sv
// two-stage synchronisers with rising-edge ticks for oscillator pins
`timescale 1ns/1ps
module scps_edge_sync
    import scps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N_PINS-1:0] pin_in,
    output logic [N_PINS-1:0] tick
);
    logic [N_PINS-1:0] meta_r;
    logic [N_PINS-1:0] sync_r;
    logic [N_PINS-1:0] last_r;

    genvar i;
    generate
        for (i = 0; i < N_PINS; i++) begin : g_pin
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                    last_r[i] <= 1'b0;
                    tick[i] <= 1'b0;
                end else begin
                    meta_r[i] <= pin_in[i];
                    sync_r[i] <= meta_r[i];
                    last_r[i] <= sync_r[i];
                    tick[i] <= sync_r[i] & ~last_r[i];
                end
            end
        end
    endgenerate
endmodule

// >>> verilog/scps_tick_div.sv
// programmable tick divider that takes a new ratio only on wrap
`timescale 1ns/1ps
module scps_tick_div
    import scps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick_in,
    input wire logic [8:0] ratio,
    output logic tick_out
);
    logic [8:0] cnt_r;
    logic [8:0] ratio_r;

    // the ratio is latched at the wrap so a write never shortens a period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 9'h000;
            ratio_r <= 9'h001;
            tick_out <= 1'b0;
        end else if (tick_in) begin
            if (cnt_r + 9'h001 >= ratio_r) begin // [R22]
                cnt_r <= 9'h000;
                ratio_r <= (ratio == 9'h000) ? 9'h001 : ratio;
                tick_out <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 9'h001;
                tick_out <= 1'b0;
            end
        end else begin
            tick_out <= 1'b0;
        end
    end
endmodule

// >>> verilog/scps_clock_ctrl.sv
// system clock source selection, pll model, fail-safe monitor, apb slave
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module scps_clock_ctrl
    import scps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_pin_in,
    input wire logic secondary_pin_in,
    input wire logic fast_internal_rc,
    input wire logic slow_internal_rc,
    input wire logic [6:0] boot_source_config_word,
    output logic primary_pin_out,
    output logic primary_pin_oe,
    output logic sys_clk_tick,
    output logic instr_clk,
    output logic instr_tick,
    output logic periph_tick,
    output logic wdt_ref_tick,
    output logic aux_clk_tick
);
    localparam int PIN_PRI = 0;
    localparam int PIN_SEC = 1;
    localparam int PIN_FRC = 2;
    localparam int PIN_SLOW = 3;

    logic [N_PINS-1:0] pin_tick;
    scps_divisor_t div_r;
    logic [8:0] fbd_r;
    logic [1:0] aux_mode_r;
    logic [2:0] aux_div_r;
    scps_boot_cfg_t cfg_meta_r;
    scps_boot_cfg_t cfg_sync_r;
    scps_boot_cfg_t cfg_r;
    logic [1:0] boot_cnt_r;
    logic booted_r;
    logic [2:0] cur_src_r;
    logic clock_fail_r;
    logic [1:0] fail_cnt_r;
    scps_pll_state_t pll_state_r;
    logic [3:0] lock_cnt_r;
    logic [11:0] pll_acc_r;
    logic pll_tick_r;
    logic pll_ref_tick;
    logic vco_in_tick;
    logic frc_post_tick;
    logic aux_div_tick;
    logic sel_tick;
    logic pll_mode;
    logic second_pin_free;
    logic wr_en;
    logic rd_setup;
    logic fail_clr;
    logic [8:0] frc_ratio;
    logic [11:0] pll_acc_add;
    logic [3:0] pll_n2;
    logic [31:0] rd_data;
    logic rd_hit;

    scps_edge_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({slow_internal_rc, fast_internal_rc,
                 secondary_pin_in, primary_pin_in}),
        .tick(pin_tick)
    );

    // ---------------------------------------------------------------
    // apb slave: one wait-free access phase, reads captured at setup
    // ---------------------------------------------------------------
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_setup = psel & ~penable;
    assign fail_clr = wr_en && paddr == OFS_OSC_STATUS &&
                      pwdata[ST_FAIL_BIT];

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (paddr)
            OFS_CLOCK_DIVISOR: begin
                rd_data[FRC_POST_LSB +: 3] = div_r.fast_rc_postscale_sel;
                rd_data[PLL_POST_LSB +: 2] = div_r.pll_postscale_sel;
                rd_data[PLL_PRE_LSB +: 5] = div_r.pll_prescale_sel;
            end
            OFS_FEEDBACK_DIVISOR: begin
                rd_data[8:0] = fbd_r;
            end
            OFS_OSC_STATUS: begin
                rd_data[ST_SRC_LSB +: 3] = cur_src_r;
                rd_data[ST_PMODE_LSB +: 2] = cfg_r.primary_mode_sel;
                rd_data[ST_PINFN_BIT] = cfg_r.second_pin_function_bit;
                rd_data[ST_FAILSAFE_CLOCK_MONITOR_EN_BIT] = cfg_r.failsafe_clock_monitor_enable;
                rd_data[ST_LOCK_BIT] = (pll_state_r == SCPS_PLL_LOCKED);
                rd_data[ST_FAIL_BIT] = clock_fail_r;
            end
            OFS_AUX_CONTROL: begin
                rd_data[AUX_MODE_LSB +: 2] = aux_mode_r;
                rd_data[AUX_DIV_LSB +: 3] = aux_div_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_setup;
            if (rd_setup) begin
                pslverr <= ~rd_hit;
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // divisor fields; the reserved postscale code is refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r.fast_rc_postscale_sel <= FRC_POST_RST;
            div_r.pll_postscale_sel <= PLL_POST_RST;
            div_r.pll_prescale_sel <= PLL_PRE_RST;
        end else if (wr_en && paddr == OFS_CLOCK_DIVISOR) begin
            div_r.fast_rc_postscale_sel <= pwdata[FRC_POST_LSB +: 3]; // [R7]
            div_r.pll_prescale_sel <= pwdata[PLL_PRE_LSB +: 5]; // [R8]
            if (pwdata[PLL_POST_LSB +: 2] != PLL_POST_RESERVED) begin
                div_r.pll_postscale_sel <= pwdata[PLL_POST_LSB +: 2]; // [R11]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fbd_r <= PLL_FBD_RST;
        end else if (wr_en && paddr == OFS_FEEDBACK_DIVISOR) begin
            fbd_r <= pwdata[8:0]; // [R9]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_mode_r <= AUX_MODE_RST;
            aux_div_r <= AUX_DIV_RST;
        end else if (wr_en && paddr == OFS_AUX_CONTROL) begin
            aux_mode_r <= pwdata[AUX_MODE_LSB +: 2];
            aux_div_r <= pwdata[AUX_DIV_LSB +: 3];
        end
    end

    // ---------------------------------------------------------------
    // boot configuration: nonvolatile word synchronised, then caught
    // once the synchroniser has settled after reset release
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_meta_r <= '0;
            cfg_sync_r <= '0;
        end else begin
            cfg_meta_r <= boot_source_config_word;
            cfg_sync_r <= cfg_meta_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_r <= 2'h0;
            booted_r <= 1'b0;
            cfg_r.initial_source_sel <= ERASED_SOURCE; // [R5]
            cfg_r.primary_mode_sel <= PMODE_EXTERNAL;
            cfg_r.second_pin_function_bit <= 1'b0;
            cfg_r.failsafe_clock_monitor_enable <= 1'b0;
        end else if (!booted_r) begin
            if (boot_cnt_r == BOOT_SYNC_CYCLES) begin
                booted_r <= 1'b1;
                cfg_r <= cfg_sync_r; // [R6]
            end else begin
                boot_cnt_r <= boot_cnt_r + 2'h1;
            end
        end
    end

    // ---------------------------------------------------------------
    // active source: boot choice, replaced by fast rc on clock loss
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_src_r <= ERASED_SOURCE; // [R5]
        end else if (!booted_r && boot_cnt_r == BOOT_SYNC_CYCLES) begin
            cur_src_r <= cfg_sync_r.initial_source_sel; // [R6]
        end else if (booted_r && cfg_r.failsafe_clock_monitor_enable &&
                     fail_cnt_r == FAIL_SLOW_TICKS) begin
            cur_src_r <= SRC_FAST_RC; // [R21]
        end
    end

    // monitor counts slow rc ticks with no tick from the active source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_cnt_r <= 2'h0;
        end else if (!booted_r || sel_tick || !cfg_r.failsafe_clock_monitor_enable) begin
            fail_cnt_r <= 2'h0;
        end else if (fail_cnt_r == FAIL_SLOW_TICKS) begin
            fail_cnt_r <= 2'h0;
        end else if (pin_tick[PIN_SLOW]) begin
            fail_cnt_r <= fail_cnt_r + 2'h1; // [R17] [R21]
        end
    end

    // a fresh detection outranks a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_fail_r <= 1'b0;
        end else if (booted_r && cfg_r.failsafe_clock_monitor_enable &&
                     fail_cnt_r == FAIL_SLOW_TICKS) begin
            clock_fail_r <= 1'b1; // [R21]
        end else if (fail_clr) begin
            clock_fail_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // pll: reference is primary or fast rc only, other sources bypass
    // ---------------------------------------------------------------
    assign pll_mode = (cur_src_r == SRC_FAST_RC_PLL) ||
                      (cur_src_r == SRC_PRIMARY_PLL); // [R16]
    assign pll_ref_tick = pll_mode &&
        ((cur_src_r == SRC_PRIMARY_PLL) ? pin_tick[PIN_PRI]
                                        : pin_tick[PIN_FRC]); // [R16]

    scps_tick_div u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(pll_ref_tick),
        .ratio({3'h0, 6'(div_r.pll_prescale_sel) + PLL_PRE_OFFSET}), // [R8]
        .tick_out(vco_in_tick)
    );

    // rate model: each vco-input tick adds m, each output tick spends n2;
    // the output is bounded by pclk, so only the average ratio is exact
    assign pll_n2 = scps_pll_post_div(div_r.pll_postscale_sel); // [R10]
    assign pll_acc_add = vco_in_tick ?
        12'(10'(fbd_r) + PLL_FBD_OFFSET) : 12'h000; // [R9]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_acc_r <= 12'h000;
            pll_tick_r <= 1'b0;
        end else if (pll_state_r == SCPS_PLL_OFF) begin
            pll_acc_r <= 12'h000;
            pll_tick_r <= 1'b0;
        end else if (pll_acc_r >= 12'(pll_n2)) begin
            pll_acc_r <= pll_acc_r - 12'(pll_n2) + pll_acc_add; // [R12]
            pll_tick_r <= 1'b1;
        end else begin
            pll_acc_r <= pll_acc_r + pll_acc_add;
            pll_tick_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_state_r <= SCPS_PLL_OFF;
            lock_cnt_r <= 4'h0;
        end else begin
            unique case (pll_state_r)
                SCPS_PLL_OFF: begin
                    lock_cnt_r <= 4'h0;
                    if (pll_mode) begin
                        pll_state_r <= SCPS_PLL_ACQ;
                    end
                end
                SCPS_PLL_ACQ: begin
                    if (!pll_mode) begin
                        pll_state_r <= SCPS_PLL_OFF;
                    end else if (lock_cnt_r == PLL_LOCK_TICKS) begin
                        pll_state_r <= SCPS_PLL_LOCKED;
                    end else if (vco_in_tick) begin
                        lock_cnt_r <= lock_cnt_r + 4'h1;
                    end
                end
                SCPS_PLL_LOCKED: begin
                    if (!pll_mode) begin
                        pll_state_r <= SCPS_PLL_OFF;
                    end
                end
                default: begin
                    pll_state_r <= SCPS_PLL_OFF;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // fast rc postscaler, forced to sixteen in its fixed-ratio mode
    // ---------------------------------------------------------------
    assign frc_ratio = (cur_src_r == SRC_FAST_RC_DIV16) ? DIV_SIXTEEN :
        scps_frc_post_div(div_r.fast_rc_postscale_sel); // [R3] [R7]

    scps_tick_div u_frc_post (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(pin_tick[PIN_FRC]),
        .ratio(frc_ratio),
        .tick_out(frc_post_tick)
    );

    // source decode; reserved primary mode gives no clock without the pll,
    // so the monitor will see it as lost
    always_comb begin
        sel_tick = 1'b0;
        unique case (cur_src_r)
            SRC_FAST_RC: sel_tick = pin_tick[PIN_FRC]; // [R2]
            SRC_FAST_RC_PLL: sel_tick = pll_tick_r; // [R2]
            SRC_PRIMARY,
            SRC_PRIMARY_PLL: begin
                if (cur_src_r == SRC_PRIMARY_PLL) begin
                    sel_tick = pll_tick_r; // [R2]
                end else if (cfg_r.primary_mode_sel == PMODE_EXTERNAL ||
                             cfg_r.primary_mode_sel == PMODE_STD_CRYSTAL ||
                             cfg_r.primary_mode_sel == PMODE_HS_CRYSTAL) begin
                    sel_tick = pin_tick[PIN_PRI]; // [R4]
                end
            end
            SRC_SECONDARY: sel_tick = pin_tick[PIN_SEC]; // [R3]
            SRC_SLOW_RC: sel_tick = pin_tick[PIN_SLOW]; // [R3]
            SRC_FAST_RC_DIV16,
            SRC_FAST_RC_POST: sel_tick = frc_post_tick; // [R3]
        endcase
    end

    // ---------------------------------------------------------------
    // system clock, halved for instruction and peripheral time base;
    // at 25 MHz pclk the halved rate stays well under the 40 MHz limit
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_clk_tick <= 1'b0;
            instr_clk <= 1'b0;
            instr_tick <= 1'b0;
            periph_tick <= 1'b0;
        end else begin
            sys_clk_tick <= sel_tick;
            if (sel_tick) begin
                instr_clk <= ~instr_clk; // [R1] [R18]
            end
            instr_tick <= sel_tick & instr_clk; // [R1]
            periph_tick <= sel_tick & instr_clk; // [R1]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_ref_tick <= 1'b0;
        end else begin
            wdt_ref_tick <= pin_tick[PIN_SLOW]; // [R17]
        end
    end

    // second primary pin is free for external clock or non-primary modes
    assign second_pin_free = (cur_src_r != SRC_PRIMARY &&
                              cur_src_r != SRC_PRIMARY_PLL) ||
                             cfg_r.primary_mode_sel == PMODE_EXTERNAL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_pin_out <= 1'b0;
            primary_pin_oe <= 1'b0;
        end else begin
            primary_pin_oe <= second_pin_free &&
                              !cfg_r.second_pin_function_bit; // [R19]
            primary_pin_out <= instr_clk; // [R19]
        end
    end

    // ---------------------------------------------------------------
    // auxiliary oscillator: independent of the system clock choice
    // ---------------------------------------------------------------
    scps_tick_div u_aux_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick_in(pin_tick[PIN_SEC] && aux_mode_r != AUX_OFF), // [R20]
        .ratio(scps_frc_post_div(~aux_div_r)),
        .tick_out(aux_div_tick)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_clk_tick <= 1'b0;
        end else begin
            aux_clk_tick <= aux_div_tick; // [R20]
        end
    end

endmodule

// >>> tb/scps_clock_ctrl_sva.sv
// port assertions for the clock source block
`timescale 1ns/1ps
module scps_clock_ctrl_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic slow_internal_rc,
    input wire logic primary_pin_out,
    input wire logic primary_pin_oe,
    input wire logic sys_clk_tick,
    input wire logic instr_clk,
    input wire logic instr_tick,
    input wire logic periph_tick,
    input wire logic wdt_ref_tick
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_instr_toggle: assert property (
        sys_clk_tick |-> ##[0:1] $changed(instr_clk)) else $error("no toggle");
    a_toggle_cause: assert property (
        $changed(instr_clk) |-> sys_clk_tick || $past(sys_clk_tick))
        else $error("stray toggle");
    a_instr_spacing: assert property (
        instr_tick |=> !instr_tick) else $error("instr tick too fast");
    a_periph_same: assert property (
        instr_tick == periph_tick) else $error("periph tick apart");
    a_pin_copy: assert property (
        primary_pin_oe |-> primary_pin_out == $past(instr_clk))
        else $error("pin out not clock copy");
    a_wdt_follow: assert property (
        $rose(slow_internal_rc) |-> ##[1:4] wdt_ref_tick)
        else $error("watchdog tick missing");
    a_wdt_single: assert property (
        wdt_ref_tick |=> !wdt_ref_tick) else $error("watchdog tick long");
    a_pready_pulse: assert property (
        psel && !penable |=> pready ##1 !pready) else $error("bad pready");
endmodule
bind scps_clock_ctrl scps_clock_ctrl_sva scps_clock_ctrl_sva_inst (.*);

// >>> tb/tb_top.sv
// self-checking bench for the clock source block
`timescale 1ns/1ps
module tb_top;
    import scps_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic primary_pin_in, secondary_pin_in, fast_internal_rc;
    logic slow_internal_rc, primary_pin_out, primary_pin_oe;
    logic sys_clk_tick, instr_clk, instr_tick, periph_tick;
    logic wdt_ref_tick, aux_clk_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [6:0] boot_source_config_word;
    logic [64:0] q[$], e;
    int bad_count, n_tests, cyc;
    scps_clock_ctrl scps_clock_ctrl_inst (.*);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // stand-in oscillators; periods of 6, 10, 8 and 4 pclk cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        fast_internal_rc <= cyc % 6 < 3;
        slow_internal_rc <= cyc % 10 < 5;
        primary_pin_in <= cyc % 8 < 4;
        secondary_pin_in <= cyc % 4 < 2;
        if (cyc == 6000) begin
            bad_count++;
            conclude();
        end
    end
    task conclude;
        if (bad_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // each finished transfer settles the oldest noted expectation
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            e = q.pop_front();
            check(prdata & e[63:32], e[31:0], "prdata");
            check(32'(pslverr), 32'(e[64]), "pslverr");
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [64:0] x);
        q.push_back(x);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x, m, input logic r);
        apb(1'b0, a, 32'h0, {r, m, x & m});
    endtask
    // first gaps after a ratio change may straddle the old ratio
    task gap(input logic [1:0] s, input int x);
        int n;
        repeat (4) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while ((s[1] ? aux_clk_tick : s[0] ? wdt_ref_tick
                : instr_tick) !== 1'b1);
        end
        check(n, x, "tick gap");
    endtask
    initial begin
        logic [31:0] d;
        logic [6:0] c;
        logic [1:0] p;
        void'($urandom(32'h8a264284));
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {fast_internal_rc, slow_internal_rc} = '0;
        {primary_pin_in, secondary_pin_in} = '0;
        boot_source_config_word = '1;
        for (int i = 0; i < 10; i++) begin
            c = {3'(i), 2'($urandom_range(2)), 1'($urandom), 1'b0};
            if (i > 7)
                c = i == 8 ? 7'h7f : 7'h7e;
            @(posedge pclk);
            presetn <= 1'b0;
            boot_source_config_word <= c;
            repeat (16) @(posedge pclk);
            presetn <= 1'b1;
            repeat (6) @(posedge pclk);
            rd(OFS_OSC_STATUS, 32'({c[0], c[1], c[3:2], 1'b0, c[6:4]}),
                ~32'h100, 0);
            check(32'(primary_pin_oe),
                32'(!c[1] && (c[6:5] != 2'h1 || c[3:2] == 0)), "oe");
            if (i == 1) begin
                // stand-in rc: /2, x50, /8 keeps every pll stage in range
                apb(1'b1, OFS_CLOCK_DIVISOR, 32'hc0,
                    65'h0);
                repeat (120) @(posedge pclk);
                rd(OFS_OSC_STATUS, 32'h100, 32'h100, 1'b0);
            end
        end
        rd(OFS_CLOCK_DIVISOR, 32'h40, '1, 0);
        rd(OFS_FEEDBACK_DIVISOR, 32'h30, '1, 0);
        p = 2'h1;
        for (int k = 0; k < 4; k++) begin
            d = $urandom;
            d[7:6] = 2'(k);
            if (k != 2)
                p = 2'(k);
            apb(1'b1, OFS_CLOCK_DIVISOR, d, 65'h0);
            rd(OFS_CLOCK_DIVISOR, (d & 32'h71f) | 32'({p, 6'h0}),
                '1, 0);
            apb(1'b1, OFS_FEEDBACK_DIVISOR, ~d, 65'h0);
            rd(OFS_FEEDBACK_DIVISOR, ~d & 32'h1ff, '1, 0);
        end
        rd(8'h10, 32'h0, '1, 1);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, OFS_CLOCK_DIVISOR, 32'h40 | (k << 8), 65'h0);
            gap(2'h0, 12 << k);
        end
        gap(2'h1, 10);
        apb(1'b1, OFS_AUX_CONTROL, 32'he00, 65'h0);
        rd(OFS_AUX_CONTROL, 32'he00, '1, 1'b0);
        gap(2'h2, 8);
        // reserved primary mode without the pll never ticks, so the monitor must fall back
        presetn <= 1'b0;
        boot_source_config_word <= 7'h2d;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (40) @(posedge pclk);
        rd(OFS_OSC_STATUS, 32'h2b0, '1, 1'b0);
        apb(1'b1, OFS_OSC_STATUS, 32'h200, 65'h0);
        rd(OFS_OSC_STATUS, 32'h0b0, '1, 1'b0);
        conclude();
    end
endmodule
